//--- src/xpc_host.v
// Function
// (R01) device reset low disables outputs, sets currents to code 0111
// (R02) chip select high makes device ignore strobes and float data
// (R03) chip select and write low, read high, stores data into first rank
// (R04) chip select and read low, device drives second rank onto data
// (R05) chip select and update low copies all first rank to second rank
// (R06) write plus update low gives transparent programming, gated by read strobe
// (R07) controller holds update low at least 10 ns per pulse
// (R08) controller holds reset low at least 10 ns per pulse
// (R09) device has 34 rows of two-rank 6-bit latches
// (R10) connection word picks input; separate word holds output current
// (R11) controller may preload several outputs before one update
// (R12) matrix follows only second rank, unchanged by first-rank writes
// (R13) all controls except reset gated by chip select
// (R14) releasing chip select keeps matrix and all latch contents
// (R15) controls are level sensitive, function lasts while held
// (R16) address bit six picks bank; low six bits pick output, 63 broadcasts
// (R17) data 63 in connection bank disables the addressed output
// (R18) current code in low four bits, upper two ignored
// (R19) read strobe has priority over write strobe
// (R20) writes to reserved outputs 34 to 62 change nothing
// (R21) controller floats data bus before read strobe until readback ends
`include "xpc_regs.vh"
module xpc_host (
    input wire clock,
    input wire rst_n,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire [2:0] cmd_op,
    input wire cmd_bank,
    input wire [5:0] cmd_out,
    input wire [5:0] cmd_data,
    output reg [5:0] rd_data_ff,
    output reg rd_valid_ff,
    output reg cmd_error_ff,
    output reg dev_reset_n_ff,
    output reg chip_sel_n_ff,
    output reg write_n_ff,
    output reg second_rank_read_n_ff,
    output reg rank_transfer_n_ff,
    output reg [6:0] ctrl_addr_ff,
    output reg [5:0] ctrl_data_o_ff,
    output reg ctrl_data_oe_n_ff,
    input wire [5:0] ctrl_data_i
);
    localparam S_IDLE = 6'h01;
    localparam S_SETUP = 6'h02;
    localparam S_PULSE = 6'h04;
    localparam S_HOLD = 6'h08;
    localparam S_RDWAIT = 6'h10;
    localparam S_RDEND = 6'h20;
    // pulse counts rounded up to whole clocks
    localparam integer WP_I = `XPC_WP_CYC;
    localparam integer UW_I = `XPC_UW_CYC;
    localparam integer TW_I = `XPC_TW_CYC;
    localparam integer RD_I = `XPC_RDE_CYC + `XPC_SYNC_CYC;
    localparam integer RHA_I = `XPC_RHA_CYC;
    localparam [3:0] WP_CYC = WP_I[3:0];
    localparam [3:0] UW_CYC = UW_I[3:0];
    localparam [3:0] TW_CYC = TW_I[3:0];
    localparam [3:0] RD_CYC = RD_I[3:0];
    localparam [3:0] RHA_CYC = RHA_I[3:0];
    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg [3:0] cnt_ff;
    reg [3:0] nxt_cnt;
    reg [2:0] op_ff;
    reg [5:0] din_meta_ff;
    reg [5:0] din_sync_ff;
    reg bad_addr;
    reg refuse;
    reg take;
    reg [3:0] pulse_len;
    // pin input synchroniser
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            din_meta_ff <= 6'h00;
            din_sync_ff <= 6'h00;
        end else begin
            din_meta_ff <= ctrl_data_i;
            din_sync_ff <= din_meta_ff;
        end
    end
    assign cmd_ready = (state_ff == S_IDLE);
    // command decode and refusal
    always @* begin
        bad_addr = (cmd_out >= `XPC_NUM_OUTPUTS) && (cmd_out != `XPC_BROADCAST); // (R09) (R20)
        refuse = bad_addr && (cmd_op != `XPC_CMD_UPDATE) && (cmd_op != `XPC_CMD_RESET); // (R20)
        take = cmd_valid && !refuse;
    end
    // strobe width per command
    always @* begin
        case (op_ff)
            `XPC_CMD_RESET: pulse_len = TW_CYC; // (R08)
            `XPC_CMD_WRITE: pulse_len = WP_CYC;
            default: pulse_len = UW_CYC; // (R07)
        endcase
    end
    // next state and counters
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            S_IDLE: begin
                nxt_cnt = 4'h0;
                if (take) begin
                    nxt_state = S_SETUP;
                end
            end
            S_SETUP: begin
                nxt_cnt = 4'h0;
                if (op_ff == `XPC_CMD_READ) begin
                    nxt_state = S_RDWAIT;
                end else begin
                    nxt_state = S_PULSE;
                end
            end
            S_PULSE: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff + 4'h1 >= pulse_len) begin
                    nxt_state = S_HOLD;
                    nxt_cnt = 4'h0;
                end
            end
            S_RDWAIT: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff + 4'h1 >= RD_CYC) begin
                    nxt_state = S_RDEND;
                    nxt_cnt = 4'h0;
                end
            end
            // address and chip select stay past read strobe release
            S_RDEND: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff + 4'h1 >= RHA_CYC) begin
                    nxt_state = S_HOLD;
                end
            end
            S_HOLD: begin
                nxt_cnt = 4'h0;
                nxt_state = S_IDLE;
            end
            default: nxt_state = S_IDLE;
        endcase
    end
    // registered pins and results
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            cnt_ff <= 4'h0;
            op_ff <= `XPC_CMD_WRITE;
            rd_data_ff <= 6'h00;
            rd_valid_ff <= 1'b0;
            cmd_error_ff <= 1'b0;
            dev_reset_n_ff <= 1'b1;
            chip_sel_n_ff <= 1'b1;
            write_n_ff <= 1'b1;
            second_rank_read_n_ff <= 1'b1;
            rank_transfer_n_ff <= 1'b1;
            ctrl_addr_ff <= 7'h00;
            ctrl_data_o_ff <= 6'h00;
            ctrl_data_oe_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            rd_valid_ff <= 1'b0;
            cmd_error_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    // refused commands leave every pin as it was
                    cmd_error_ff <= cmd_valid && refuse; // (R20)
                    if (take) begin
                        op_ff <= cmd_op;
                        ctrl_addr_ff <= {cmd_bank, cmd_out}; // (R16)
                        if (cmd_bank == `XPC_BANK_CURR) begin
                            ctrl_data_o_ff <= {2'b00, cmd_data[3:0]}; // (R18)
                        end else begin
                            ctrl_data_o_ff <= cmd_data; // (R10) (R17)
                        end
                        if (cmd_op != `XPC_CMD_RESET) begin
                            chip_sel_n_ff <= 1'b0; // (R13)
                        end
                        ctrl_data_oe_n_ff <= !(cmd_op == `XPC_CMD_WRITE
                            || cmd_op == `XPC_CMD_TRANSP);
                    end
                end
                S_SETUP: begin
                    case (op_ff)
                        `XPC_CMD_WRITE: write_n_ff <= 1'b0; // (R03) (R11) (R12)
                        `XPC_CMD_UPDATE: rank_transfer_n_ff <= 1'b0; // (R05)
                        `XPC_CMD_RESET: dev_reset_n_ff <= 1'b0; // (R01)
                        `XPC_CMD_TRANSP: begin
                            write_n_ff <= 1'b0; // (R06)
                            rank_transfer_n_ff <= 1'b0;
                        end
                        `XPC_CMD_READ: second_rank_read_n_ff <= 1'b0; // (R04) (R19) (R21)
                        default: chip_sel_n_ff <= 1'b1;
                    endcase
                end
                S_PULSE: begin
                    if (nxt_state == S_HOLD) begin
                        write_n_ff <= 1'b1; // (R15)
                        rank_transfer_n_ff <= 1'b1;
                        dev_reset_n_ff <= 1'b1;
                    end
                end
                S_RDWAIT: begin
                    if (nxt_state == S_RDEND) begin
                        // sample after access time and synchroniser
                        rd_data_ff <= din_sync_ff;
                        rd_valid_ff <= 1'b1;
                        second_rank_read_n_ff <= 1'b1;
                    end
                end
                S_HOLD: begin
                    chip_sel_n_ff <= 1'b1; // (R02) (R14)
                    ctrl_data_oe_n_ff <= 1'b1;
                end
                default: chip_sel_n_ff <= 1'b1;
            endcase
        end
    end
endmodule // xpc_host

//--- shared/xpc_regs.vh
`ifndef XPC_REGS_VH
`define XPC_REGS_VH
// pin field layout
`define XPC_ADDR_W 7
`define XPC_DATA_W 6
`define XPC_BANK_BIT 6
`define XPC_BANK_CONN 1'b0
`define XPC_BANK_CURR 1'b1
`define XPC_NUM_OUTPUTS 34
`define XPC_BROADCAST 6'h3F
`define XPC_DISABLE_CODE 6'h3F
`define XPC_CURR_RESET 4'h7
// timing, ns and clock period ps
`define XPC_CLK_PS 5000
`define XPC_T_WP_NS 10
`define XPC_T_UW_NS 10
`define XPC_T_TW_NS 10
`define XPC_T_RDE_NS 30
`define XPC_T_RHA_NS 5
`define XPC_SYNC_CYC 2
`define XPC_WP_CYC ((`XPC_T_WP_NS * 1000 + `XPC_CLK_PS - 1) / `XPC_CLK_PS)
`define XPC_UW_CYC ((`XPC_T_UW_NS * 1000 + `XPC_CLK_PS - 1) / `XPC_CLK_PS)
`define XPC_TW_CYC ((`XPC_T_TW_NS * 1000 + `XPC_CLK_PS - 1) / `XPC_CLK_PS)
`define XPC_RDE_CYC ((`XPC_T_RDE_NS * 1000 + `XPC_CLK_PS - 1) / `XPC_CLK_PS)
`define XPC_RHA_CYC ((`XPC_T_RHA_NS * 1000 + `XPC_CLK_PS - 1) / `XPC_CLK_PS)
// command codes
`define XPC_CMD_WRITE 3'h0
`define XPC_CMD_UPDATE 3'h1
`define XPC_CMD_READ 3'h2
`define XPC_CMD_RESET 3'h3
`define XPC_CMD_TRANSP 3'h4
`endif

//--- test/xpc_dev_model.sv
module xpc_dev_model (
    input wire rst_n, input wire cs_n, input wire we_n, input wire re_n, input wire upd_n,
    input wire [6:0] addr, input wire [5:0] d_o, input wire oe_n, output logic [5:0] bus
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] r1 [128];
    logic [5:0] r2 [128];
    logic [5:0] last = 6'h00;
    wire drv = rst_n && !cs_n && !re_n;
    always @(rst_n, cs_n, we_n, re_n, upd_n, addr, d_o) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) r1[i] = i < 64 ? 6'h3F : 6'h07;
            r2 = r1;
        end else if (!cs_n) begin
            if (!we_n && re_n)
                for (int i = 0; i < 34; i++)
                    if (addr[5:0] == 6'h3F || addr[5:0] == i)
                        r1[addr[6] * 64 + i] = addr[6] ? {2'h0, d_o[3:0]} : d_o;
            if (!upd_n) r2 = r1;
        end
    end
    always @* begin
        if (!oe_n) last = d_o;
        else if (drv) last = r2[addr];
    end
    // released bus shows inverse of last level
    assign bus = !oe_n ? d_o : drv ? r2[addr] : ~last;
endmodule // xpc_dev_model

//--- test/xpc_host_props.sv
module xpc_host_props (
    input wire clock, input wire rst_n, input wire cmd_error_ff, input wire dev_reset_n_ff,
    input wire chip_sel_n_ff, input wire write_n_ff, input wire second_rank_read_n_ff,
    input wire rank_transfer_n_ff, input wire [6:0] ctrl_addr_ff,
    input wire [5:0] ctrl_data_o_ff, input wire ctrl_data_oe_n_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_upd_width: assert property ($fell(rank_transfer_n_ff) |-> !rank_transfer_n_ff[*2])
        else $error("update pulse too short");
    a_rst_width: assert property ($fell(dev_reset_n_ff) |-> !dev_reset_n_ff[*2])
        else $error("reset pulse too short");
    a_read_float: assert property (!second_rank_read_n_ff |-> ctrl_data_oe_n_ff)
        else $error("bus driven during readback");
    a_read_sel: assert property (!second_rank_read_n_ff |-> !chip_sel_n_ff)
        else $error("read without chip select");
    a_write_gate: assert property (!write_n_ff |-> !chip_sel_n_ff && second_rank_read_n_ff
        && !ctrl_data_oe_n_ff)
        else $error("write strobe badly qualified");
    a_addr_valid: assert property (!chip_sel_n_ff && rank_transfer_n_ff
        |-> ctrl_addr_ff[5:0] < 34 || ctrl_addr_ff[5:0] == 6'h3F)
        else $error("reserved output addressed");
    a_err_quiet: assert property (cmd_error_ff
        |-> chip_sel_n_ff && write_n_ff && ctrl_data_oe_n_ff)
        else $error("refused command toggled pins");
    a_curr_upper: assert property (!write_n_ff && ctrl_addr_ff[6]
        |-> ctrl_data_o_ff[5:4] == 2'h0)
        else $error("current data upper bits set");
    a_addr_hold: assert property ($rose(second_rank_read_n_ff)
        |-> $stable(ctrl_addr_ff) && !chip_sel_n_ff)
        else $error("address not held after read");
endmodule // xpc_host_props

//--- test/xpc_host_tb.sv
module xpc_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, rst_n = 0, cmd_valid = 0, cmd_bank = 0, err;
    logic [2:0] cmd_op = 0;
    logic [5:0] cmd_out = 0, cmd_data = 0, rdv, rd_data_ff, ctrl_data_o_ff, bus;
    logic [6:0] ctrl_addr_ff;
    logic cmd_ready, rd_valid_ff, cmd_error_ff, dev_reset_n_ff, chip_sel_n_ff, write_n_ff;
    logic second_rank_read_n_ff, rank_transfer_n_ff, ctrl_data_oe_n_ff;
    int fail_count = 0, cmp_count = 0, r1e [128], r2e [128];
    xpc_host dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_out(cmd_out), .cmd_data(cmd_data),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cmd_error_ff(cmd_error_ff),
        .dev_reset_n_ff(dev_reset_n_ff), .chip_sel_n_ff(chip_sel_n_ff), .write_n_ff(write_n_ff),
        .second_rank_read_n_ff(second_rank_read_n_ff), .rank_transfer_n_ff(rank_transfer_n_ff),
        .ctrl_addr_ff(ctrl_addr_ff), .ctrl_data_o_ff(ctrl_data_o_ff),
        .ctrl_data_oe_n_ff(ctrl_data_oe_n_ff), .ctrl_data_i(bus));
    xpc_dev_model dev (.rst_n(dev_reset_n_ff), .cs_n(chip_sel_n_ff), .we_n(write_n_ff),
        .re_n(second_rank_read_n_ff), .upd_n(rank_transfer_n_ff), .addr(ctrl_addr_ff),
        .d_o(ctrl_data_o_ff), .oe_n(ctrl_data_oe_n_ff), .bus(bus));
    initial forever #2.5 clock = ~clock;
    task automatic summarize;
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [5:0] g, input int e);
        cmp_count++;
        if (g !== e[5:0]) begin
            fail_count++;
            $display("unexpected %0t got %h exp %h", $time, g, e[5:0]);
        end
    endtask
    task automatic chk_flag(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic step(input [2:0] op, input b, input [5:0] o, input [5:0] d);
        logic res;
        res = o > 33 && o != 6'h3F && op != 1 && op != 3;
        err = 0;
        rdv = 'x;
        {cmd_op, cmd_bank, cmd_out, cmd_data, cmd_valid} = {op, b, o, d, 1'b1};
        @(posedge clock) #1 cmd_valid = 0;
        for (int n = 0; n < 30; n++) begin
            if (cmd_error_ff === 1'b1) err = 1;
            if (rd_valid_ff === 1'b1) rdv = rd_data_ff;
            if (n > 0 && cmd_ready === 1'b1) break;
            @(posedge clock) #1;
        end
        chk_flag(err, res);
        chk_flag(cmd_ready, 1'b1);
        if (!res && (op == 0 || op == 4))
            for (int i = 0; i < 34; i++)
                if (o == 6'h3F || o == i) r1e[b * 64 + i] = b ? d & 15 : d;
        if (op == 3)
            for (int i = 0; i < 128; i++) r1e[i] = i < 64 ? 63 : 7;
        if (!res && op != 0 && op != 2) r2e = r1e;
    endtask
    task automatic rdchk(input b, input [5:0] o);
        step(2, b, o, 0);
        chk(rdv, r2e[b * 64 + o]);
    endtask
    task automatic allchk;
        for (int b = 0; b < 2; b++)
            for (int o = 0; o < 34; o++) rdchk(b, o);
    endtask
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
    initial begin
        logic [5:0] o;
        logic b;
        void'($urandom(31901));
        for (int i = 0; i < 128; i++) r1e[i] = i < 64 ? 63 : 7;
        r2e = r1e;
        repeat (20) @(posedge clock);
        #1 rst_n = 1;
        step(3, 0, 0, 0);
        allchk();
        repeat (6) begin
            o = $urandom % 34;
            b = $urandom % 2;
            step(0, b, o, $urandom);
            rdchk(b, o);
        end
        step(1, 0, 0, 0);
        allchk();
        step(0, 0, 63, $urandom % 34);
        step(0, 1, 63, $urandom);
        step(0, 0, 5, 63);
        step(0, 0, 40, 1);
        step(2, 1, 50, 0);
        step(4, 1, 9, $urandom);
        step(4, 0, 33, $urandom % 34);
        allchk();
        step(3, 0, 0, 0);
        allchk();
        summarize();
    end
endmodule // xpc_host_tb
bind xpc_host xpc_host_props u_props (.clock(clock), .rst_n(rst_n), .cmd_error_ff(cmd_error_ff),
    .dev_reset_n_ff(dev_reset_n_ff), .chip_sel_n_ff(chip_sel_n_ff), .write_n_ff(write_n_ff),
    .second_rank_read_n_ff(second_rank_read_n_ff), .rank_transfer_n_ff(rank_transfer_n_ff),
    .ctrl_addr_ff(ctrl_addr_ff), .ctrl_data_o_ff(ctrl_data_o_ff),
    .ctrl_data_oe_n_ff(ctrl_data_oe_n_ff));
